// *** inc/tmc_pkg.sv ***
// Package with register map, field layout, modes and timing constants of the timer mode and clock control.
// Functional notes
// - Nonzero channel B output mode drives its pin only when direction selects output, the wave mode is not reserved and, in PWM, the mode is 10 or 11.
// - Non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear on match set at bottom, 11 inverse, 01 reserved.
// - Phase correct: 10 clear on up match set on down, 11 inverse, 01 reserved.
// - In PWM, compare B equal to TOP with upper bit set acts at TOP.
// - Reserved bits 3:2 of control A and 5:4 of control B read zero.
// - Wave mode from control A bits 1:0 and control B bit 3; 4, 6 reserved.
// - TOP is 0xFF or compare A; compare values update immediately, at TOP or bottom.
// - Overflow flag sets at MAX in 0,2,3, bottom in 1,5, TOP in 7.
// - A channel B force strobe in a non-PWM mode applies an immediate match using current output mode bits.
// - A forced match sets no flag, raises no interrupt, never clears the counter.
// - Force strobe bits always read as zero.
// - Clock select: stop, undivided, divide 8/64/256/1024, pin falling, pin rising.
// - External pin edges count even when that pin is an output.
// - Compare values are compared with the counter continuously.
// - A counter write suppresses the compare match on the next timer tick.
package tmc_pkg;
  localparam logic [7:0] TMC_OFS_CTRL_A  = 8'h24;
  localparam logic [7:0] TMC_OFS_CTRL_B  = 8'h25;
  localparam logic [7:0] TMC_OFS_COUNT   = 8'h26;
  localparam logic [7:0] TMC_OFS_CMP_A   = 8'h27;
  localparam logic [7:0] TMC_OFS_CMP_B   = 8'h28;
  localparam logic [7:0] TMC_OFS_STATUS  = 8'h29;
  localparam logic [7:0] TMC_OFS_MASK    = 8'h2A;
  localparam logic [7:0] TMC_CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] TMC_CTRL_B_MASK = 8'h0F;
  localparam logic [7:0] TMC_RESET_VAL   = 8'h00;
  localparam logic [7:0] TMC_MAX         = 8'hFF;
  localparam logic [7:0] TMC_BOTTOM      = 8'h00;
  localparam int         TMC_OMB_HI      = 5;
  localparam int         TMC_OMB_LO      = 4;
  localparam int         TMC_WGH_BIT     = 3;
  localparam int         TMC_FOA_BIT     = 7;
  localparam int         TMC_FOB_BIT     = 6;
  localparam int         TMC_ST_OVF      = 0;
  localparam int         TMC_ST_MA       = 1;
  localparam int         TMC_ST_MB       = 2;
  localparam int         TMC_ST_W        = 3;
  localparam logic [10:0] TMC_DIV8       = 11'd7;
  localparam logic [10:0] TMC_DIV64      = 11'd63;
  localparam logic [10:0] TMC_DIV256     = 11'd255;
  localparam logic [10:0] TMC_DIV1024    = 11'd1023;
  typedef enum logic [2:0] {
    TMC_CS_STOP = 3'h0, TMC_CS_DIV1 = 3'h1, TMC_CS_DIV8 = 3'h2, TMC_CS_DIV64 = 3'h3,
    TMC_CS_DIV256 = 3'h4, TMC_CS_DIV1024 = 3'h5, TMC_CS_EXT_FALL = 3'h6, TMC_CS_EXT_RISE = 3'h7
  } tmc_clk_sel_t;
  typedef enum logic [2:0] {
    TMC_WG_NORMAL = 3'h0, TMC_WG_PC_FF = 3'h1, TMC_WG_CTC = 3'h2, TMC_WG_FAST_FF = 3'h3,
    TMC_WG_RES4 = 3'h4, TMC_WG_PC_OCA = 3'h5, TMC_WG_RES6 = 3'h6, TMC_WG_FAST_OCA = 3'h7
  } tmc_wave_mode_t;
  typedef enum logic [2:0] {
    TMC_DIR_UP = 3'b001, TMC_DIR_DOWN = 3'b010, TMC_DIR_IDLE = 3'b100
  } tmc_dir_t;
endpackage : tmc_pkg

// *** inc/tmc_tick_if.sv ***
// Interface carrying the count tick and clock select between the top and the clock selector.
`timescale 1ns/10ps
interface tmc_tick_if;
  logic [2:0] clock_select;
  logic       ext_count_sync;
  logic       tick;
  modport top (output clock_select, output ext_count_sync, input tick);
  modport sel (input clock_select, input ext_count_sync, output tick);
endinterface : tmc_tick_if

// *** verilog/tmc_clk_sel.sv ***
// Clock selector: prescaler, external edge detector and tick multiplexer.
`timescale 1ns/10ps
module tmc_clk_sel (
  input  wire logic core_clk,
  input  wire logic arst_n,
  tmc_tick_if.sel   tk
);
  logic [10:0] pre_q;
  logic        ext_prev_q;
  logic        tick_q;
  logic        rise_w;
  logic        fall_w;
  logic        tick_d;

  // Edge detection on the already synchronised external count input.
  assign rise_w = tk.ext_count_sync & ~ext_prev_q;
  assign fall_w = ~tk.ext_count_sync & ext_prev_q;

  // Tick selection from the prescaler taps or external edges.
  always_comb begin
    unique case (tk.clock_select)
      tmc_pkg::TMC_CS_STOP:     tick_d = 1'b0;
      tmc_pkg::TMC_CS_DIV1:     tick_d = 1'b1;
      tmc_pkg::TMC_CS_DIV8:     tick_d = (pre_q[2:0] == tmc_pkg::TMC_DIV8[2:0]);
      tmc_pkg::TMC_CS_DIV64:    tick_d = (pre_q[5:0] == tmc_pkg::TMC_DIV64[5:0]);
      tmc_pkg::TMC_CS_DIV256:   tick_d = (pre_q[7:0] == tmc_pkg::TMC_DIV256[7:0]);
      tmc_pkg::TMC_CS_DIV1024:  tick_d = (pre_q == tmc_pkg::TMC_DIV1024);
      tmc_pkg::TMC_CS_EXT_FALL: tick_d = fall_w;
      tmc_pkg::TMC_CS_EXT_RISE: tick_d = rise_w;
    endcase
  end

  // Free running prescaler and registered tick.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q      <= 11'h000;
      ext_prev_q <= 1'b0;
      tick_q     <= 1'b0;
    end else begin
      pre_q      <= (pre_q == tmc_pkg::TMC_DIV1024) ? 11'h000 : pre_q + 11'd1;
      ext_prev_q <= tk.ext_count_sync;
      tick_q     <= tick_d;
    end
  end

  assign tk.tick = tick_q;
endmodule : tmc_clk_sel

// *** verilog/tmc_top.sv ***
// Timer mode and clock control with APB registers, counter, channel B waveform and interrupt.
`timescale 1ns/10ps
module tmc_top (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_input,
  input  wire logic        chan_b_dir_out,
  output logic             chan_b_wave_out,
  output logic             chan_b_pin_oe,
  output logic             chan_a_match,
  output logic             irq
);
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [7:0] cnt_q;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] cmp_a_act_q;
  logic [7:0] cmp_b_act_q;
  logic [tmc_pkg::TMC_ST_W-1:0] status_q;
  logic [tmc_pkg::TMC_ST_W-1:0] mask_q;
  logic       ocb_q;
  logic       oe_q;
  logic       mta_q;
  logic       irq_q;
  logic       blk_q;
  logic       ext_s1_q;
  logic       ext_s2_q;
  logic [31:0] prdata_q;
  logic       pready_q;
  logic       pslverr_q;
  tmc_pkg::tmc_dir_t dir_q;
  tmc_pkg::tmc_dir_t dir_d;
  tmc_tick_if tk ();

  tmc_clk_sel tmc_clk_sel_inst (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tk       (tk)
  );

  // Two flip-flop synchroniser; the pin counts whatever its direction.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_count_input;
      ext_s2_q <= ext_s1_q;
    end
  end

  // APB decode and strobes.
  logic       acc_w;
  logic       wr_w;
  logic       rd_w;
  logic [9:0] widx_w;
  logic       hit_w;
  assign acc_w  = psel & penable & ~pready_q;
  assign widx_w = paddr[11:2];
  assign hit_w  = (widx_w >= 10'(tmc_pkg::TMC_OFS_CTRL_A)) && (widx_w <= 10'(tmc_pkg::TMC_OFS_MASK))
                  && (paddr[1:0] == 2'b00);
  assign wr_w   = acc_w & pwrite & hit_w;
  assign rd_w   = acc_w & ~pwrite & hit_w;

  function automatic logic wsel(input logic [9:0] idx, input logic [7:0] ofs);
    wsel = (idx == 10'(ofs));
  endfunction : wsel

  logic wr_a_w, wr_b_w, wr_cnt_w, wr_ca_w, wr_cb_w, wr_msk_w, rd_st_w;
  assign wr_a_w   = wr_w & wsel(widx_w, tmc_pkg::TMC_OFS_CTRL_A);
  assign wr_b_w   = wr_w & wsel(widx_w, tmc_pkg::TMC_OFS_CTRL_B);
  assign wr_cnt_w = wr_w & wsel(widx_w, tmc_pkg::TMC_OFS_COUNT);
  assign wr_ca_w  = wr_w & wsel(widx_w, tmc_pkg::TMC_OFS_CMP_A);
  assign wr_cb_w  = wr_w & wsel(widx_w, tmc_pkg::TMC_OFS_CMP_B);
  assign wr_msk_w = wr_w & wsel(widx_w, tmc_pkg::TMC_OFS_MASK);
  assign rd_st_w  = rd_w & wsel(widx_w, tmc_pkg::TMC_OFS_STATUS);

  // Mode decode.
  tmc_pkg::tmc_wave_mode_t wm_w;
  logic       pc_w;
  logic       fast_w;
  logic       nonpwm_w;
  logic       res_mode_w;
  logic [1:0] omb_w;
  assign wm_w       = tmc_pkg::tmc_wave_mode_t'({ctrl_b_q[tmc_pkg::TMC_WGH_BIT], ctrl_a_q[1:0]});
  assign pc_w       = (wm_w == tmc_pkg::TMC_WG_PC_FF) || (wm_w == tmc_pkg::TMC_WG_PC_OCA);
  assign fast_w     = (wm_w == tmc_pkg::TMC_WG_FAST_FF) || (wm_w == tmc_pkg::TMC_WG_FAST_OCA);
  assign nonpwm_w   = (wm_w == tmc_pkg::TMC_WG_NORMAL) || (wm_w == tmc_pkg::TMC_WG_CTC);
  assign res_mode_w = (wm_w == tmc_pkg::TMC_WG_RES4) || (wm_w == tmc_pkg::TMC_WG_RES6);
  assign omb_w      = ctrl_a_q[tmc_pkg::TMC_OMB_HI:tmc_pkg::TMC_OMB_LO];

  // TOP is compare A in CLEAR_ON_MATCH_MODE, mode 5 and mode 7, else MAX.
  logic [7:0] top_sel_w;
  assign top_sel_w = (wm_w == tmc_pkg::TMC_WG_CTC || wm_w == tmc_pkg::TMC_WG_PC_OCA
                      || wm_w == tmc_pkg::TMC_WG_FAST_OCA) ? cmp_a_q : tmc_pkg::TMC_MAX;

  // Counter events, compared continuously against the active compare values.
  logic tick_w, at_top_w, at_bot_w, m_a_w, m_b_w, ovf_w, cnt_wrap_w, top_rule_w;
  assign tick_w     = tk.tick & ~res_mode_w;
  assign at_top_w   = (cnt_q == top_sel_w);
  assign at_bot_w   = (cnt_q == tmc_pkg::TMC_BOTTOM);
  assign m_a_w      = tick_w & ~blk_q & (cnt_q == cmp_a_act_q);
  assign m_b_w      = tick_w & ~blk_q & (cnt_q == cmp_b_act_q);
  assign top_rule_w = (pc_w | fast_w) & omb_w[1] & (cmp_b_act_q == top_sel_w);
  assign cnt_wrap_w = at_top_w & ~pc_w;
  assign ovf_w = tick_w & (((wm_w == tmc_pkg::TMC_WG_NORMAL || wm_w == tmc_pkg::TMC_WG_CTC
                  || wm_w == tmc_pkg::TMC_WG_FAST_FF) && cnt_q == tmc_pkg::TMC_MAX)
                  || (pc_w && at_bot_w && dir_q == tmc_pkg::TMC_DIR_DOWN)
                  || (wm_w == tmc_pkg::TMC_WG_FAST_OCA && at_top_w));

  // Count direction state for phase correct counting.
  always_comb begin
    dir_d = dir_q;
    unique case (dir_q)
      tmc_pkg::TMC_DIR_UP:   if (tick_w && pc_w && at_top_w) dir_d = tmc_pkg::TMC_DIR_DOWN;
      tmc_pkg::TMC_DIR_DOWN: if (tick_w && (!pc_w || at_bot_w)) dir_d = tmc_pkg::TMC_DIR_UP;
      tmc_pkg::TMC_DIR_IDLE: dir_d = tmc_pkg::TMC_DIR_UP;
      default:               dir_d = tmc_pkg::TMC_DIR_UP;
    endcase
  end

  // Next waveform level for channel B.
  logic force_b_w, upd_w, ocb_d;
  assign force_b_w = wr_b_w & pwdata[tmc_pkg::TMC_FOB_BIT] & nonpwm_w;
  assign upd_w = (nonpwm_w) | (pc_w & tick_w & at_top_w) | (fast_w & tick_w & at_bot_w);
  always_comb begin
    ocb_d = ocb_q;
    if (nonpwm_w && (m_b_w || force_b_w)) begin
      unique case (omb_w)
        2'b01:   ocb_d = ~ocb_q;
        2'b10:   ocb_d = 1'b0;
        2'b11:   ocb_d = 1'b1;
        default: ocb_d = ocb_q;
      endcase
    end else if (fast_w && omb_w[1] && tick_w) begin
      if (m_b_w && !top_rule_w) ocb_d = omb_w[0];
      else if (top_rule_w && at_top_w) ocb_d = ~omb_w[0];
      else if (at_bot_w && !top_rule_w) ocb_d = ~omb_w[0];
    end else if (pc_w && omb_w[1] && tick_w) begin
      if (top_rule_w && at_top_w) ocb_d = ~omb_w[0];
      else if (m_b_w && !top_rule_w) ocb_d = (dir_q == tmc_pkg::TMC_DIR_UP) ? omb_w[0] : ~omb_w[0];
    end
  end

  // Pin takes the waveform only in a legal mode and encoding with direction set to output.
  logic oe_d;
  assign oe_d = (omb_w != 2'b00) & chan_b_dir_out & ~res_mode_w
                & (nonpwm_w | omb_w[1]);

  // Control registers; force bits are strobes and never stored.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_a_q <= tmc_pkg::TMC_RESET_VAL;
      ctrl_b_q <= tmc_pkg::TMC_RESET_VAL;
      cmp_a_q  <= tmc_pkg::TMC_RESET_VAL;
      cmp_b_q  <= tmc_pkg::TMC_RESET_VAL;
      mask_q   <= '0;
    end else begin
      if (wr_a_w) ctrl_a_q <= pwdata[7:0] & tmc_pkg::TMC_CTRL_A_MASK;
      if (wr_b_w) ctrl_b_q <= pwdata[7:0] & tmc_pkg::TMC_CTRL_B_MASK;
      if (wr_ca_w) cmp_a_q <= pwdata[7:0];
      if (wr_cb_w) cmp_b_q <= pwdata[7:0];
      if (wr_msk_w) mask_q <= pwdata[tmc_pkg::TMC_ST_W-1:0];
    end
  end

  // Counter, active compare values, waveform and direction.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q       <= tmc_pkg::TMC_RESET_VAL;
      cmp_a_act_q <= tmc_pkg::TMC_RESET_VAL;
      cmp_b_act_q <= tmc_pkg::TMC_RESET_VAL;
      dir_q       <= tmc_pkg::TMC_DIR_IDLE;
      blk_q       <= 1'b0;
      ocb_q       <= 1'b0;
      oe_q        <= 1'b0;
      mta_q       <= 1'b0;
    end else begin
      dir_q <= dir_d;
      ocb_q <= ocb_d;
      oe_q  <= oe_d;
      mta_q <= m_a_w;
      if (upd_w) begin
        cmp_a_act_q <= cmp_a_q;
        cmp_b_act_q <= cmp_b_q;
      end
      if (wr_cnt_w) blk_q <= 1'b1;
      else if (tick_w) blk_q <= 1'b0;
      if (wr_cnt_w) cnt_q <= pwdata[7:0];
      else if (tick_w) begin
        if (pc_w) cnt_q <= (dir_d == tmc_pkg::TMC_DIR_DOWN) ? cnt_q - 8'd1 : cnt_q + 8'd1;
        else if (cnt_wrap_w) cnt_q <= tmc_pkg::TMC_BOTTOM;
        else cnt_q <= cnt_q + 8'd1;
      end
    end
  end

  // Sticky status, cleared by a status read; a new event wins over the clear.
  logic [tmc_pkg::TMC_ST_W-1:0] ev_w;
  assign ev_w = {m_b_w, m_a_w, ovf_w};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_q <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= (rd_st_w ? '0 : status_q) | ev_w;
      irq_q    <= |(((rd_st_w ? '0 : status_q) | ev_w) & mask_q);
    end
  end

  // Read data mux; reserved and strobe bits read zero.
  logic [31:0] rmux_w;
  always_comb begin
    rmux_w = 32'h0000_0000;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_CTRL_A)) rmux_w[7:0] = ctrl_a_q;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_CTRL_B)) rmux_w[7:0] = ctrl_b_q;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_COUNT))  rmux_w[7:0] = cnt_q;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_CMP_A))  rmux_w[7:0] = cmp_a_q;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_CMP_B))  rmux_w[7:0] = cmp_b_q;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_STATUS)) rmux_w[tmc_pkg::TMC_ST_W-1:0] = status_q;
    if (wsel(widx_w, tmc_pkg::TMC_OFS_MASK))   rmux_w[tmc_pkg::TMC_ST_W-1:0] = mask_q;
  end

  // APB answer one cycle after the access phase begins.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc_w;
      pslverr_q <= acc_w & ~hit_w;
      if (acc_w) prdata_q <= (hit_w && !pwrite) ? rmux_w : 32'h0000_0000;
    end
  end

  assign tk.clock_select   = ctrl_b_q[2:0];
  assign tk.ext_count_sync = ext_s2_q;
  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign chan_b_wave_out   = ocb_q;
  assign chan_b_pin_oe     = oe_q;
  assign chan_a_match      = mta_q;
  assign irq               = irq_q;
endmodule : tmc_top

// *** testbench/tmc_assertions.sv ***
// Port-level checker of the timer mode and clock control block.
`timescale 1ns/10ps
module tmc_assertions (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ext_count_input,
  input wire logic        chan_b_dir_out,
  input wire logic        chan_b_wave_out,
  input wire logic        chan_b_pin_oe,
  input wire logic        chan_a_match,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Bus answers come one cycle after the access starts and last one cycle.
  a_ready_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("pready not one cycle late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad error answer");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  // Reserved and strobe bits read back as zero.
  a_ctrl_a_resv: assert property (pready && !pwrite && paddr == 12'h090 |-> prdata[3:2] == 2'b00)
    else $error("control A reserved bits set");
  a_ctrl_b_resv: assert property (pready && !pwrite && paddr == 12'h094 |-> prdata[7:4] == 4'h0)
    else $error("control B reserved or strobe bits set");
  // The pin is driven only when its direction selects output.
  a_oe_needs_dir: assert property (chan_b_pin_oe |-> $past(chan_b_dir_out))
    else $error("pin driven with direction input");
  a_match_pulse: assert property (chan_a_match |=> !chan_a_match)
    else $error("match pulse longer than one cycle");
  // Main scenarios.
  c_irq: cover property ($rose(irq));
  c_oe: cover property ($rose(chan_b_pin_oe));
  c_err: cover property (pslverr);
endmodule : tmc_assertions
bind tmc_top tmc_assertions tmc_assertions_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_count_input(ext_count_input), .chan_b_dir_out(chan_b_dir_out),
  .chan_b_wave_out(chan_b_wave_out), .chan_b_pin_oe(chan_b_pin_oe), .chan_a_match(chan_a_match), .irq(irq));

// *** testbench/test_tmc_top.sv ***
// Self-checking bench for the timer mode and clock control block.
`timescale 1ns/10ps
module test_tmc_top;
  logic        core_clk, arst_n, psel, penable, pwrite, ext_count_input, chan_b_dir_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, chan_b_wave_out, chan_b_pin_oe, chan_a_match, irq, err;
  int          n_errors, comparisons, i, t, h, n;
  logic [7:0]  w;
  // Overflow table: mode, clock select, start count, window of cycles (hi 0 means none).
  int md[11] = '{2, 0, 0, 1, 3, 5, 0, 0, 0, 0, 7};
  int cs[11] = '{1, 0, 1, 1, 1, 1, 2, 3, 4, 5, 1};
  int st[11] = '{2, 252, 2, 2, 2, 2, 252, 252, 252, 252, 2};
  int lo[11] = '{0, 0, 240, 490, 240, 20, 24, 192, 768, 3072, 8};
  int hi[11] = '{0, 0, 270, 530, 270, 45, 34, 258, 1026, 4098, 25};
  // PWM table: mode, output mode, compare B, period, high cycles.
  int pm[6] = '{3, 3, 1, 1, 3, 1};
  int pc[6] = '{2, 3, 2, 3, 2, 2};
  int pb[6] = '{64, 64, 64, 64, 255, 255};
  int pp[6] = '{256, 256, 510, 510, 256, 510};
  int pe[6] = '{64, 192, 128, 382, 255, 510};
  // Clock of 25 ns period.
  always #12.5 core_clk = ~core_clk;
  tmc_top tmc_top_inst (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_input(ext_count_input), .chan_b_dir_out(chan_b_dir_out), .chan_b_wave_out(chan_b_wave_out),
    .chan_b_pin_oe(chan_b_pin_oe), .chan_a_match(chan_a_match), .irq(irq));
  function automatic logic [11:0] ra(input logic [7:0] o);
    return {2'b00, o, 2'b00};
  endfunction : ra
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  // One bus transfer; holds the request until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (k >= 20) begin
      n_errors++;
      end_sim();
    end
  endtask : apb
  task automatic wait_irq(input int lim);
    t = 0;
    while (irq !== 1'b1 && t < lim) begin
      @(posedge core_clk);
      t++;
    end
  endtask : wait_irq
  // Main sequence.
  initial begin
    core_clk = 1'b0;
    arst_n = 1'b0;
    {psel, penable, pwrite, ext_count_input, chan_b_dir_out} = 5'b00001;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    void'($urandom(32'hd06f));
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    apb(0, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
    check(rd, 32'h0000_0000);
    apb(0, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
    check(rd, 32'h0000_0000);
    for (i = 0; i < 6; i++) begin
      w = (i == 0) ? 8'hFF : 8'($urandom);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), {24'h0, w});
      apb(0, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
      check(rd, {24'h0, w & 8'hF3});
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), {24'h0, w & 8'h3F});
      apb(0, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
      check(rd, {24'h0, w & 8'h0F});
    end
    apb(0, 12'h0FC, 0);
    check({rd[30:0], err}, 32'h0000_0001);
    apb(1, 12'h091, 32'h0000_00FF);
    check(32'(err), 1);
    $display("Register test done");
    // Forced matches with the counter stopped in normal mode.
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
    apb(1, ra(tmc_pkg::TMC_OFS_CMP_A), 8'h90);
    apb(1, ra(tmc_pkg::TMC_OFS_CMP_B), 8'h80);
    apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
    for (i = 0; i < 4; i++) begin
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), {26'h0, i < 2 ? 2'(3 - i) : 2'b01, 4'h0});
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 8'h40);
      check(32'(chan_b_wave_out), 32'(i % 2 == 0));
      check(32'(chan_b_pin_oe), 1);
      apb(0, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
      check(rd, 32'h0000_0000);
    end
    apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
    check(rd, 32'h0000_0000);
    chan_b_dir_out <= 1'b0;
    repeat (2) @(posedge core_clk);
    check(32'(chan_b_pin_oe), 0);
    chan_b_dir_out <= 1'b1;
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
    check(32'(chan_b_pin_oe), 0);
    $display("Force test done");
    // Overflow timing per mode and clock select.
    for (i = 0; i < 11; i++) begin
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
      apb(1, ra(tmc_pkg::TMC_OFS_CMP_A), 8'h10);
      apb(1, ra(tmc_pkg::TMC_OFS_COUNT), st[i]);
      apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
      apb(1, ra(tmc_pkg::TMC_OFS_MASK), 1);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), md[i] % 4);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), (md[i] / 4) * 8 + cs[i]);
      wait_irq(4200);
      if (hi[i] == 0) check(32'(irq), 0);
      else check(32'(t >= lo[i] && t <= hi[i]), 1);
      if (hi[i] != 0 && t >= 4200) end_sim();
    end
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
    apb(1, ra(tmc_pkg::TMC_OFS_MASK), 0);
    check(32'(irq), 0);
    apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
    check(32'(rd[0]), 1);
    apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
    check(32'(rd[0]), 0);
    $display("Overflow test done");
    // A counter write blocks the match at the next tick; the next real match pulses once.
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
    apb(1, ra(tmc_pkg::TMC_OFS_COUNT), 8'h10);
    apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 1);
    apb(0, ra(tmc_pkg::TMC_OFS_STATUS), 0);
    check(32'(rd[1]), 0);
    h = 0;
    repeat (300) begin
      @(posedge core_clk);
      h += int'(chan_a_match === 1'b1);
    end
    check(h, 1);
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
    $display("Match block test done");
    // External pin edges, falling then rising.
    for (i = 6; i < 8; i++) begin
      n = 3 + $urandom % 8;
      apb(1, ra(tmc_pkg::TMC_OFS_COUNT), 0);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), i);
      repeat (n) begin
        ext_count_input <= 1'b1;
        repeat (4) @(posedge core_clk);
        ext_count_input <= 1'b0;
        repeat (4) @(posedge core_clk);
      end
      repeat (6) @(posedge core_clk);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
      apb(0, ra(tmc_pkg::TMC_OFS_COUNT), 0);
      check(rd, n);
    end
    $display("External clock test done");
    // Duty of the channel B waveform over one period.
    for (i = 0; i < 6; i++) begin
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 0);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 0);
      apb(1, ra(tmc_pkg::TMC_OFS_CMP_B), pb[i]);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), pc[i] * 16 + pm[i] % 4);
      apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), (pm[i] / 4) * 8 + 1);
      repeat (600) @(posedge core_clk);
      h = 0;
      repeat (pp[i]) begin
        @(posedge core_clk);
        h += int'(chan_b_wave_out === 1'b1);
      end
      check(32'(h >= pe[i] - 4 && h <= pe[i] + 4), 1);
      check(32'(chan_b_pin_oe), 1);
    end
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 8'h13);
    check(32'(chan_b_pin_oe), 0);
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_A), 8'h20);
    apb(1, ra(tmc_pkg::TMC_OFS_CTRL_B), 8'h09);
    check(32'(chan_b_pin_oe), 0);
    $display("Waveform test done");
    end_sim();
  end
endmodule : test_tmc_top
